/* logic/snmcs_consts.svh */
// constants of the serial nonvolatile memory command block
// assumes inclusion by bare name from the design files
`ifndef SNMCS_CONSTS_SVH
`define SNMCS_CONSTS_SVH
`define SNMCS_OPC_BITS    8
`define SNMCS_ADDR_BITS   16
`define SNMCS_DUMMY_BITS  8
`define SNMCS_ID_BITS     32
`define SNMCS_LONG_BITS   64
`define SNMCS_ST_STATUS_PROTECT_ENABLE     7
`define SNMCS_ST_BP_HI    3
`define SNMCS_ST_BP_LO    2
`define SNMCS_ST_RESET    6'h00
`define SNMCS_FIFO_DEPTH  16
`define SNMCS_ENTRY_W     25
`define SNMCS_SS_LAST     8'hff
`endif

/* logic/snmcs_core.sv */
// spi slave command decoder of a 64k x 8 nonvolatile byte memory
// assumes i_ref_clk at 125 MHz and spi pins slower than a quarter of it
// Operation
// - each command opens with an 8-bit opcode; fourteen opcodes are known
// - deselect before the eighth opcode bit discards the command
// - set-latch opcode sets the write latch, needed before every write
// - clear-latch opcode clears the latch; writes are then refused
// - status read drives status byte on falling edges, repeating while clocked
// - status write takes 8 bits, bits 1 and 0 ignored
// - array read takes 16-bit address, then shifts out the byte
// - further read bytes come from incremented addresses, wrapping at the top
// - array write commits a byte after its eighth data bit
// - further write bytes go to incremented addresses, wrapping at the top
// - fast read inserts 8 dummy bits after the address
// - identifier read sends 32 bits, maker, continuation, two product bytes
// - after the 32nd identifier bit the output holds its last value
// - unique value read sends 64 bits on falling edges
// - serial number is programmed once; later programs change nothing
// - serial number read sends 64 bits, zeros when never programmed
// - special write uses low address byte of a 256-byte sector
// - special write bytes increment without wrap; data past top dropped
// - special reads use low address byte, fast one adds dummies, no wrap
// - two protect bits shield none, upper quarter, upper half or all
// - input sampled on rising clock edge, output changes on falling edge
// - latch and protect bits gate array writes; latch, protect enable and pin jointly gate status writes
`timescale 1ns/1ps
`default_nettype none
`include "snmcs_consts.svh"

module snmcs_fifo #(
    parameter int WIDTH = 25,
    parameter int DEPTH = 16
) (
    input  wire logic             i_ref_clk,
    input  wire logic             i_reset,
    input  wire logic             i_valid,
    output logic                  o_ready,
    input  wire logic [WIDTH-1:0] i_data,
    output logic                  o_valid,
    input  wire logic             i_ready,
    output logic [WIDTH-1:0]      o_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] buf_q [DEPTH];
    logic [AW:0]      wr_q;
    logic [AW:0]      rd_q;
    logic             full;
    logic             empty;

    assign empty = (wr_q == rd_q);
    assign full = (wr_q[AW] != rd_q[AW]) && (wr_q[AW-1:0] == rd_q[AW-1:0]);
    assign o_ready = ~full;
    assign o_valid = ~empty;
    assign o_data = buf_q[rd_q[AW-1:0]];

    always_ff @(posedge i_ref_clk) begin
        if (i_valid && !full) begin
            buf_q[wr_q[AW-1:0]] <= i_data;
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_reset) begin
            wr_q <= '0;
        end else if (i_valid && !full) begin
            wr_q <= wr_q + 1'b1;
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_reset) begin
            rd_q <= '0;
        end else if (i_ready && !empty) begin
            rd_q <= rd_q + 1'b1;
        end
    end
endmodule // snmcs_fifo

module snmcs_core #(
    parameter logic [31:0] DEV_ID = 32'h5a_7f_12_34,          // value arbitrary
    parameter logic [63:0] UNIQUE_VALUE = 64'h0011_2233_4455_6677 // value arbitrary
) (
    input  wire logic i_ref_clk,
    input  wire logic i_reset,
    input  wire logic i_cs_n,
    input  wire logic i_sck,
    input  wire logic i_si,
    input  wire logic i_write_protect_n,
    input  wire logic i_commit_hold,
    output logic      o_so,
    output logic      o_so_oe_n,
    output logic      o_wr_ready,
    output logic      o_write_enable_latch,
    output logic [7:0] o_status
);
    localparam int P_CS = 3;
    localparam int P_SCK = 2;
    localparam int P_SI = 1;
    localparam int P_WP = 0;

    logic [3:0]   s1_q;
    logic [3:0]   s2_q;
    logic [3:0]   s3_q;
    logic [3:0]   fl_q;
    logic         sel;
    logic         cs_off;
    logic         sck_rise;
    logic         sck_fall;
    snmcs_pkg::snmcs_state_t state_q;
    logic [7:0]   opc_q;
    logic [6:0]   cnt_q;
    logic [63:0]  in_sr_q;
    logic [63:0]  in_nxt;
    logic [15:0]  addr_q;
    logic [63:0]  out_sr_q;
    logic [6:0]   out_cnt_q;
    logic         wel_q;
    logic [7:2]   stat_q;
    logic [63:0]  sn_q;
    logic         sn_done_q;
    logic         ss_end_q;
    logic         so_q;
    logic         oe_n_q;
    logic [7:0]   mem_q [65536];
    logic [7:0]   ss_q [256];
    logic [7:0]   stat_rd;
    logic         is_arr_wr;
    logic         is_ss_wr;
    logic         is_ss;
    logic         is_mem_rd;
    logic         is_long;
    logic         is_fast;
    logic         opc_done;
    logic         wbyte;
    logic         ld;
    logic         adv;
    logic         push;
    logic         stat_wr_ev;
    logic         sn_ev;
    logic [63:0]  lv;
    logic [6:0]   out_len;
    logic         f_ready;
    logic         f_valid;
    logic [`SNMCS_ENTRY_W-1:0] f_dout;

    function automatic logic prot_hit(input logic [1:0] bp, input logic [15:0] a);
        case (bp)
            2'b00: prot_hit = 1'b0;
            2'b01: prot_hit = (a[15:14] == 2'b11);
            2'b10: prot_hit = a[15];
            default: prot_hit = 1'b1;
        endcase
    endfunction

    // three-stage pin synchronisers
    always_ff @(posedge i_ref_clk) begin
        s1_q <= {i_cs_n, i_sck, i_si, i_write_protect_n};
        s2_q <= s1_q;
        s3_q <= s2_q;
    end

    // a level counts once stages two and three agree
    for (genvar g = 0; g < 4; g++) begin : g_flt
        always_ff @(posedge i_ref_clk) begin
            if (i_reset) begin
                fl_q[g] <= (g == P_CS);
            end else if (s2_q[g] == s3_q[g]) begin
                fl_q[g] <= s3_q[g];
            end
        end
    end

    assign sel = ~fl_q[P_CS];
    assign cs_off = sel && s2_q[P_CS] && s3_q[P_CS];
    assign sck_rise = sel && s2_q[P_SCK] && s3_q[P_SCK] && !fl_q[P_SCK];
    assign sck_fall = sel && !s2_q[P_SCK] && !s3_q[P_SCK] && fl_q[P_SCK];
    assign in_nxt = {in_sr_q[62:0], fl_q[P_SI]};

    assign is_arr_wr = (opc_q == snmcs_pkg::array_write_cmd);
    assign is_ss_wr = (opc_q == snmcs_pkg::special_sector_write_cmd);
    assign is_ss = is_ss_wr || (opc_q == snmcs_pkg::special_sector_read_cmd)
                   || (opc_q == snmcs_pkg::special_sector_fast_read_cmd);
    assign is_fast = (opc_q == snmcs_pkg::fast_array_read_cmd)
                     || (opc_q == snmcs_pkg::special_sector_fast_read_cmd);
    assign is_mem_rd = is_fast || (opc_q == snmcs_pkg::array_read_cmd)
                       || (opc_q == snmcs_pkg::special_sector_read_cmd);
    assign is_long = (opc_q == snmcs_pkg::identifier_read_cmd)
                     || (opc_q == snmcs_pkg::unique_value_read_cmd)
                     || (opc_q == snmcs_pkg::serial_number_fetch_cmd);

    assign opc_done = sck_rise && (state_q == snmcs_pkg::st_opcode) && (cnt_q == 7'd7);
    assign wbyte = sck_rise && (state_q == snmcs_pkg::st_wdata)
                   && (cnt_q[2:0] == 3'd7) && (is_arr_wr || is_ss_wr);
    assign stat_wr_ev = sck_rise && (state_q == snmcs_pkg::st_wdata)
                        && (opc_q == snmcs_pkg::status_write_cmd) && (cnt_q == 7'd7);
    assign sn_ev = sck_rise && (state_q == snmcs_pkg::st_wdata)
                   && (opc_q == snmcs_pkg::serial_number_program_cmd) && (cnt_q == 7'd63);

    // command phase sequencer
    always_ff @(posedge i_ref_clk) begin
        if (i_reset || cs_off) begin
            state_q <= snmcs_pkg::st_opcode;
            cnt_q <= 7'd0;
        end else if (sck_rise) begin
            cnt_q <= cnt_q + 7'd1;
            unique case (state_q)
                snmcs_pkg::st_opcode: begin
                    if (cnt_q == 7'd7) begin
                        cnt_q <= 7'd0;
                        case (in_nxt[7:0])
                            snmcs_pkg::status_read_cmd,
                            snmcs_pkg::identifier_read_cmd,
                            snmcs_pkg::unique_value_read_cmd,
                            snmcs_pkg::serial_number_fetch_cmd:
                                state_q <= snmcs_pkg::st_out;
                            snmcs_pkg::status_write_cmd,
                            snmcs_pkg::serial_number_program_cmd:
                                state_q <= snmcs_pkg::st_wdata;
                            snmcs_pkg::array_read_cmd,
                            snmcs_pkg::array_write_cmd,
                            snmcs_pkg::fast_array_read_cmd,
                            snmcs_pkg::special_sector_write_cmd,
                            snmcs_pkg::special_sector_read_cmd,
                            snmcs_pkg::special_sector_fast_read_cmd:
                                state_q <= snmcs_pkg::st_addr;
                            default: state_q <= snmcs_pkg::st_ignore;
                        endcase
                    end
                end
                snmcs_pkg::st_addr: begin
                    if (cnt_q == 7'd15) begin
                        cnt_q <= 7'd0;
                        if (is_fast) begin
                            state_q <= snmcs_pkg::st_dummy;
                        end else if (is_arr_wr || is_ss_wr) begin
                            state_q <= snmcs_pkg::st_wdata;
                        end else begin
                            state_q <= snmcs_pkg::st_out;
                        end
                    end
                end
                snmcs_pkg::st_dummy: begin
                    if (cnt_q == 7'd7) begin
                        cnt_q <= 7'd0;
                        state_q <= snmcs_pkg::st_out;
                    end
                end
                snmcs_pkg::st_wdata: begin
                    if (stat_wr_ev || sn_ev) begin
                        state_q <= snmcs_pkg::st_ignore;
                    end
                end
                snmcs_pkg::st_out: state_q <= snmcs_pkg::st_out;
                snmcs_pkg::st_ignore: state_q <= snmcs_pkg::st_ignore;
            endcase
        end
    end

    // input shifter on rising edges
    always_ff @(posedge i_ref_clk) begin
        if (i_reset) begin
            in_sr_q <= 64'h0;
        end else if (sck_rise) begin
            in_sr_q <= in_nxt;
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_reset) begin
            opc_q <= 8'h00;
        end else if (opc_done) begin
            opc_q <= in_nxt[7:0];
        end
    end

    // write enable latch
    always_ff @(posedge i_ref_clk) begin
        if (i_reset) begin
            wel_q <= 1'b0;
        end else if (opc_done && in_nxt[7:0] == snmcs_pkg::set_write_latch_cmd) begin
            wel_q <= 1'b1;
        end else if (opc_done && in_nxt[7:0] == snmcs_pkg::clear_write_latch_cmd) begin
            wel_q <= 1'b0;
        end
    end

    // status bits 7..2; bits 1 and 0 of the data are dropped
    always_ff @(posedge i_ref_clk) begin
        if (i_reset) begin
            stat_q <= `SNMCS_ST_RESET;
        end else if (stat_wr_ev && wel_q
                     && !(stat_q[`SNMCS_ST_STATUS_PROTECT_ENABLE] && !fl_q[P_WP])) begin
            stat_q <= in_nxt[7:2];
        end
    end

    // one-time serial number
    always_ff @(posedge i_ref_clk) begin
        if (i_reset) begin
            sn_q <= 64'h0;
            sn_done_q <= 1'b0;
        end else if (sn_ev && wel_q && !sn_done_q) begin
            sn_q <= in_nxt;
            sn_done_q <= 1'b1;
        end
    end

    assign ld = sck_fall && (state_q == snmcs_pkg::st_out)
                && (is_long ? (out_cnt_q == 7'd0) : (out_cnt_q[2:0] == 3'd0));
    assign adv = wbyte || (ld && is_mem_rd);

    // address register with wrap or special-sector stop
    always_ff @(posedge i_ref_clk) begin
        if (i_reset) begin
            addr_q <= 16'h0;
            ss_end_q <= 1'b0;
        end else if (sck_rise && state_q == snmcs_pkg::st_addr && cnt_q == 7'd15) begin
            addr_q <= is_ss ? {8'h00, in_nxt[7:0]} : in_nxt[15:0];
            ss_end_q <= 1'b0;
        end else if (adv) begin
            if (is_ss && addr_q[7:0] == `SNMCS_SS_LAST) begin
                ss_end_q <= 1'b1;
            end else begin
                addr_q <= addr_q + 16'h1;
            end
        end
    end

    assign push = wbyte && wel_q
                  && (is_ss_wr ? !ss_end_q
                      : !prot_hit(stat_q[`SNMCS_ST_BP_HI:`SNMCS_ST_BP_LO], addr_q));

    snmcs_fifo #(
        .WIDTH (`SNMCS_ENTRY_W),
        .DEPTH (`SNMCS_FIFO_DEPTH)
    ) u_fifo (
        .i_ref_clk (i_ref_clk),
        .i_reset   (i_reset),
        .i_valid   (push),
        .o_ready   (f_ready),
        .i_data    ({is_ss_wr, addr_q, in_nxt[7:0]}),
        .o_valid   (f_valid),
        .i_ready   (!i_commit_hold),
        .o_data    (f_dout)
    );

    // commit queued bytes to the arrays
    always_ff @(posedge i_ref_clk) begin
        if (f_valid && !i_commit_hold) begin
            if (f_dout[24]) begin
                ss_q[f_dout[15:8]] <= f_dout[7:0];
            end else begin
                mem_q[f_dout[23:8]] <= f_dout[7:0];
            end
        end
    end

    assign stat_rd = {stat_q, wel_q, 1'b0};

    always_comb begin
        lv = 64'h0;
        out_len = 7'd64;
        case (opc_q)
            snmcs_pkg::status_read_cmd: lv[63:56] = stat_rd;
            snmcs_pkg::identifier_read_cmd: begin
                lv[63:32] = DEV_ID;
                out_len = 7'd32;
            end
            snmcs_pkg::unique_value_read_cmd: lv = UNIQUE_VALUE;
            snmcs_pkg::serial_number_fetch_cmd: lv = sn_q;
            default: begin
                if (is_ss) begin
                    lv[63:56] = ss_end_q ? 8'h00 : ss_q[addr_q[7:0]];
                end else begin
                    lv[63:56] = mem_q[addr_q];
                end
            end
        endcase
    end

    // output shifter on falling edges
    always_ff @(posedge i_ref_clk) begin
        if (i_reset || cs_off) begin
            out_cnt_q <= 7'd0;
            out_sr_q <= 64'h0;
        end else if (sck_fall && state_q == snmcs_pkg::st_out) begin
            if (ld) begin
                out_sr_q <= {lv[62:0], 1'b0};
                out_cnt_q <= out_cnt_q + 7'd1;
            end else if (!is_long || out_cnt_q < out_len) begin
                out_sr_q <= {out_sr_q[62:0], 1'b0};
                out_cnt_q <= out_cnt_q + 7'd1;
            end
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_reset) begin
            so_q <= 1'b0;
        end else if (sck_fall && state_q == snmcs_pkg::st_out) begin
            if (ld) begin
                so_q <= lv[63];
            end else if (!is_long || out_cnt_q < out_len) begin
                so_q <= out_sr_q[63];
            end
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_reset) begin
            oe_n_q <= 1'b1;
        end else begin
            oe_n_q <= !(sel && !cs_off && state_q == snmcs_pkg::st_out);
        end
    end

    assign o_so = so_q;
    assign o_so_oe_n = oe_n_q;
    assign o_wr_ready = f_ready;
    assign o_write_enable_latch = wel_q;
    assign o_status = stat_rd;

    default clocking cb @(posedge i_ref_clk);
    endclocking
    default disable iff (i_reset);

    sequence s_opc_last;
        sck_rise && state_q == snmcs_pkg::st_opcode && cnt_q == 7'd7;
    endsequence
    sequence s_deselected;
        fl_q[P_CS] [*2];
    endsequence

    property p_partial_drop;
        cs_off && !sck_rise && state_q == snmcs_pkg::st_opcode
            |=> state_q == snmcs_pkg::st_opcode && $stable(wel_q);
    endproperty
    a_partial_drop: assert property (p_partial_drop) else $error("partial opcode acted");

    property p_wel_set;
        s_opc_last ##0 in_nxt[7:0] == snmcs_pkg::set_write_latch_cmd |=> wel_q;
    endproperty
    a_wel_set: assert property (p_wel_set) else $error("latch not set");

    property p_wel_clr;
        s_opc_last ##0 in_nxt[7:0] == snmcs_pkg::clear_write_latch_cmd |=> !wel_q;
    endproperty
    a_wel_clr: assert property (p_wel_clr) else $error("latch not cleared");

    property p_stat_locked;
        stat_wr_ev && !wel_q |=> $stable(stat_q);
    endproperty
    a_stat_locked: assert property (p_stat_locked) else $error("status written unlatched");

    property p_push_ok;
        wbyte && (!wel_q || (is_arr_wr && ((stat_q[3:2] == 2'b11)
            || (stat_q[3:2] == 2'b10 && addr_q >= 16'h8000)
            || (stat_q[3:2] == 2'b01 && addr_q >= 16'hc000))))
            |=> $stable(u_fifo.wr_q);
    endproperty
    a_push_ok: assert property (p_push_ok) else $error("protected byte queued");

    property p_sn_once;
        sn_done_q |=> sn_done_q && $stable(sn_q);
    endproperty
    a_sn_once: assert property (p_sn_once) else $error("serial number altered");

    property p_so_on_fall;
        !$stable(o_so) |-> $past(sck_fall);
    endproperty
    a_so_on_fall: assert property (p_so_on_fall) else $error("output moved off fall");

    property p_oe_off;
        s_deselected |-> o_so_oe_n;
    endproperty
    a_oe_off: assert property (p_oe_off) else $error("output driven deselected");

    property p_id_hold;
        sck_fall && state_q == snmcs_pkg::st_out && is_long
            && out_len == 7'd32 && out_cnt_q == 7'd32 |=> $stable(o_so);
    endproperty
    a_id_hold: assert property (p_id_hold) else $error("identifier tail moved");

    property p_dummy;
        sck_rise && state_q == snmcs_pkg::st_dummy && cnt_q == 7'd7
            |=> state_q == snmcs_pkg::st_out && out_cnt_q == 7'd0;
    endproperty
    a_dummy: assert property (p_dummy) else $error("dummy count wrong");
endmodule // snmcs_core
`default_nettype wire

/* logic/snmcs_pkg.sv */
// types of the serial nonvolatile memory command block
// assumes nothing beyond a SystemVerilog compiler
`default_nettype none
package snmcs_pkg;
    // reserved codes 8'hce, 8'hcf, 8'hcc are never issued by the master
    typedef enum logic [7:0] {
        set_write_latch_cmd          = 8'h06,
        clear_write_latch_cmd        = 8'h04,
        status_read_cmd              = 8'h05,
        status_write_cmd             = 8'h01,
        array_read_cmd               = 8'h03,
        array_write_cmd              = 8'h02,
        fast_array_read_cmd          = 8'h0b,
        identifier_read_cmd          = 8'h9f,
        unique_value_read_cmd        = 8'h4c,
        serial_number_program_cmd    = 8'hc2,
        serial_number_fetch_cmd      = 8'hc3,
        special_sector_write_cmd     = 8'h42,
        special_sector_read_cmd      = 8'h4b,
        special_sector_fast_read_cmd = 8'h49
    } snmcs_opc_t;
    typedef enum logic [5:0] {
        st_opcode = 6'b000001,
        st_addr   = 6'b000010,
        st_dummy  = 6'b000100,
        st_out    = 6'b001000,
        st_wdata  = 6'b010000,
        st_ignore = 6'b100000
    } snmcs_state_t;
endpackage
`default_nettype wire

/* verification/serial_nv_memory_command_set_test.sv */
// self-checking bench of the command block with a master model
// assumes bench identifier and unique values in place of the design defaults, and a 125 ns link clock
`timescale 1ns/1ps
`default_nettype none
module serial_nv_memory_command_set_test;
    localparam logic [31:0] ID_V = 32'h1e2d3c4b;          // value arbitrary
    localparam logic [63:0] UQ_V = 64'h8899aabbccddeeff;  // value arbitrary
    localparam logic [63:0] SN_V = 64'h0123456789abcdef;
    logic        ref_clk = 1'b0;
    logic        reset   = 1'b1;
    logic        wp_n    = 1'b1;
    logic        hold    = 1'b0;
    logic        cs_n, sck, si, so, so_oe_n, wr_ready, write_enable_latch;
    logic [7:0]  status;
    logic [63:0] rd;
    int          err_total = 0;
    int          total_checks = 0;
    always #4 ref_clk = ~ref_clk;
    snmcs_core #(.DEV_ID(ID_V), .UNIQUE_VALUE(UQ_V)) dut (
        .i_ref_clk(ref_clk), .i_reset(reset), .i_cs_n(cs_n), .i_sck(sck),
        .i_si(si), .i_write_protect_n(wp_n), .i_commit_hold(hold), .o_so(so),
        .o_so_oe_n(so_oe_n), .o_wr_ready(wr_ready), .o_write_enable_latch(write_enable_latch),
        .o_status(status));
    snmcs_spi_master m (.o_cs_n(cs_n), .o_sck(sck), .o_si(si), .i_so(so));
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        total_checks++;
        if (got !== exp) begin
            err_total++;
            $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic frame(input logic [7:0] op, input logic [63:0] d, input int n);
        logic [63:0] x;
        m.sel();
        m.bits({56'h0, op}, 8, x); // only defined opcodes are sent
        rd = '0;
        if (n > 0) m.bits(d, n, rd);
        m.desel();
    endtask
    task automatic t_latch();
        logic [63:0] x;
        frame(snmcs_pkg::status_read_cmd, 64'h0, 16);
        chk(rd[15:0], 16'h0000);
        frame(snmcs_pkg::set_write_latch_cmd, 64'h0, 0);
        chk(write_enable_latch, 1'b1);
        // first seven bits of the clear-latch opcode, then deselect
        m.sel();
        m.bits(64'h02, 7, x);
        m.desel();
        chk(write_enable_latch, 1'b1);
        frame(snmcs_pkg::status_read_cmd, 64'h0, 16);
        chk(rd[15:0], 16'h0202);
        frame(snmcs_pkg::clear_write_latch_cmd, 64'h0, 0);
        chk(write_enable_latch, 1'b0);
    endtask
    task automatic t_array();
        frame(snmcs_pkg::set_write_latch_cmd, 64'h0, 0);
        frame(snmcs_pkg::array_write_cmd, {16'h0010, 8'h5a}, 24);
        frame(snmcs_pkg::clear_write_latch_cmd, 64'h0, 0);
        frame(snmcs_pkg::array_write_cmd, {16'h0010, 8'ha5}, 24);
        frame(snmcs_pkg::array_read_cmd, {16'h0010, 8'h00}, 24);
        chk(rd[7:0], 8'h5a);
        frame(snmcs_pkg::set_write_latch_cmd, 64'h0, 0);
        frame(snmcs_pkg::array_write_cmd, {16'hffff, 16'h1122}, 32);
        frame(snmcs_pkg::array_read_cmd, {16'hffff, 16'h0}, 32);
        chk(rd[15:0], 16'h1122);
        frame(snmcs_pkg::fast_array_read_cmd, {16'hffff, 24'h0}, 40);
        chk(rd[15:0], 16'h1122);
    endtask
    task automatic t_protect();
        frame(snmcs_pkg::array_write_cmd, {16'hbfff, 16'h0102}, 32);
        frame(snmcs_pkg::status_write_cmd, 64'hff, 8);
        chk(status, 8'hfe);
        frame(snmcs_pkg::array_write_cmd, {16'h0010, 8'h77}, 24);
        frame(snmcs_pkg::array_read_cmd, {16'h0010, 8'h00}, 24);
        chk(rd[7:0], 8'h5a);
        @(posedge ref_clk) wp_n <= 1'b0; // settled before the frame
        frame(snmcs_pkg::status_write_cmd, 64'h04, 8);
        chk(status, 8'hfe);
        @(posedge ref_clk) wp_n <= 1'b1; // settled before the frame
        frame(snmcs_pkg::status_write_cmd, 64'h04, 8);
        chk(status, 8'h06);
        frame(snmcs_pkg::array_write_cmd, {16'hbfff, 16'h4433}, 32);
        frame(snmcs_pkg::array_read_cmd, {16'hbfff, 16'h0}, 32);
        chk(rd[15:0], 16'h4402);
        frame(snmcs_pkg::status_write_cmd, 64'h00, 8);
    endtask
    task automatic t_ids();
        frame(snmcs_pkg::identifier_read_cmd, 64'h0, 40);
        chk(rd[39:0], {ID_V, {8{ID_V[0]}}});
        frame(snmcs_pkg::unique_value_read_cmd, 64'h0, 64);
        chk(rd, UQ_V);
        frame(snmcs_pkg::serial_number_fetch_cmd, 64'h0, 64);
        chk(rd, 64'h0);
        frame(snmcs_pkg::serial_number_program_cmd, SN_V, 64);
        frame(snmcs_pkg::serial_number_program_cmd, ~SN_V, 64);
        frame(snmcs_pkg::serial_number_fetch_cmd, 64'h0, 64);
        chk(rd, SN_V);
    endtask
    task automatic t_special();
        frame(snmcs_pkg::special_sector_write_cmd, {16'h12fe, 24'h010203}, 40);
        frame(snmcs_pkg::special_sector_read_cmd, {16'h34fe, 24'h0}, 40);
        chk(rd[23:0], 24'h010200);
        frame(snmcs_pkg::special_sector_fast_read_cmd, {16'h00ff, 16'h0}, 32);
        chk(rd[7:0], 8'h02);
    endtask
    task automatic t_fifo();
        logic [63:0] x;
        @(posedge ref_clk) hold <= 1'b1;
        m.sel();
        m.bits({56'h0, snmcs_pkg::array_write_cmd}, 8, x);
        m.bits(64'h0100, 16, x);
        for (int i = 0; i < 17; i++) m.bits(i, 8, x);
        m.desel();
        chk(wr_ready, 1'b0);
        @(posedge ref_clk) hold <= 1'b0;
        repeat (24) @(posedge ref_clk);
        chk(wr_ready, 1'b1);
        frame(snmcs_pkg::array_read_cmd, {16'h010e, 16'h0}, 32);
        chk(rd[15:0], 16'h0e0f);
    endtask
    task automatic t_mode3();
        logic [63:0] x;
        m.set_mode(1'b1);
        frame(snmcs_pkg::array_read_cmd, {16'h0010, 8'h00}, 24);
        chk(rd[7:0], 8'h5a);
        m.sel();
        m.bits({56'h0, snmcs_pkg::status_read_cmd}, 8, x);
        chk(so_oe_n, 1'b0);
        m.bits(64'h0, 8, x);
        m.desel();
        chk(x[7:0], 8'h02);
        chk(so_oe_n, 1'b1);
        m.set_mode(1'b0);
    endtask
    task automatic wrap_up();
        $display("checks %0d errors %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    initial begin
        #400000;
        err_total++;
        wrap_up();
    end
    initial begin
        repeat (4) @(posedge ref_clk);
        reset <= 1'b0;
        repeat (4) @(posedge ref_clk);
        t_latch();
        t_array();
        t_protect();
        t_ids();
        t_special();
        t_fifo();
        t_mode3();
        wrap_up();
    end
endmodule // serial_nv_memory_command_set_test
`default_nettype wire

/* verification/snmcs_spi_master.sv */
// spi master model, mode 0 or mode 3, driving the command block pins
// assumes the bench calls its tasks hierarchically, one frame at a time
`timescale 1ns/1ps
`default_nettype none
module snmcs_spi_master (
    output logic      o_cs_n,
    output logic      o_sck,
    output logic      o_si,
    input  wire logic i_so
);
    bit cpol = 1'b0;
    initial begin
        o_cs_n = 1'b1;
        o_sck  = 1'b0;
        o_si   = 1'b0;
    end
    // idle clock level, changed only while deselected: low mode 0, high mode 3
    task automatic set_mode(input bit m3);
        cpol = m3;
        o_sck <= m3;
        #125;
    endtask
    task automatic sel();
        o_cs_n <= 1'b0;
        #125;
    endtask
    // released data line shows the inverse of its last value
    task automatic desel();
        #125;
        o_cs_n <= 1'b1;
        o_si   <= ~o_si;
        #375;
    endtask
    // msb first, data set while sck low, sampled at the rise
    task automatic bits(input logic [63:0] d, input int n, output logic [63:0] q);
        q = '0;
        for (int i = n - 1; i >= 0; i--) begin
            if (cpol) o_sck <= 1'b0;
            o_si <= d[i];
            #62.5 o_sck <= 1'b1;
            q[i] = i_so;
            #62.5 if (!cpol) o_sck <= 1'b0;
        end
    endtask
endmodule // snmcs_spi_master
`default_nettype wire
